//--- inc/sfl_pkg.sv
package sfl_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register bus geometry and register offsets.
   localparam int unsigned SFL_AW = 8;
   localparam int unsigned SFL_DW = 32;
   localparam logic [7:0] SFL_ADDR_CFG = 8'h00;
   localparam logic [7:0] SFL_ADDR_CTRL = 8'h04;
   localparam logic [7:0] SFL_ADDR_RXLIM = 8'h08;
   localparam logic [7:0] SFL_ADDR_GAP = 8'h0C;
   localparam logic [7:0] SFL_ADDR_EVT = 8'h10;

   ////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int unsigned SFL_CFG_DMA_BIT = 0;
   localparam int unsigned SFL_CFG_MS_BIT = 1;
   localparam int unsigned SFL_CFG_TX_BIT = 2;
   localparam int unsigned SFL_CFG_RX_BIT = 3;
   localparam int unsigned SFL_CFG_CONT_BIT = 4;
   localparam int unsigned SFL_CTRL_START_BIT = 0;
   localparam int unsigned SFL_CTRL_STOP_BIT = 1;
   localparam int unsigned SFL_STAT_RUN_BIT = 0;
   localparam int unsigned SFL_STAT_STOPP_BIT = 1;
   localparam int unsigned SFL_STAT_EMPTY_BIT = 2;
   localparam int unsigned SFL_EVT_TXEMP_BIT = 0;
   localparam int unsigned SFL_EVT_TXSTOP_BIT = 1;
   localparam int unsigned SFL_EVT_RXSTOP_BIT = 2;
   localparam int unsigned SFL_RXLIM_W = 16;
   localparam int unsigned SFL_GAP_W = 4;

   ////////////////////////////////////////////////////////////////////////
   // Reset values and counts.
   localparam logic [15:0] SFL_RXLIM_RST = 16'h0000;
   localparam logic [3:0] SFL_GAP_RST = 4'h0;
   localparam logic [3:0] SFL_FRAME_LAST = 4'h7;

   ////////////////////////////////////////////////////////////////////////
   // Types.
   typedef enum logic [1:0] {
      SFL_IDLE = 2'b00,
      SFL_FRAME = 2'b01,
      SFL_GAP = 2'b11
   } sfl_state_t;

   typedef struct packed {
      logic cont;
      logic rx_en;
      logic tx_en;
      logic ms;
      logic dma;
   } sfl_cfg_t;

   typedef struct packed {
      logic rx_stop;
      logic tx_stop;
      logic tx_empty;
   } sfl_evt_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } sfl_req_t;

endpackage

//--- hw/sfl_sync.sv
`timescale 1ns/10ps
module sfl_sync (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Asynchronous level in, synchronised level out
   input wire logic i_async,
   output logic o_sync
);
   import sfl_pkg::*;

   logic [1:0] stage_q;
   logic [1:0] stage_d;

   always_comb begin
      stage_d = {stage_q[0], i_async};
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         stage_q <= 2'h0;
      end else begin
         stage_q <= stage_d;
      end
   end

   assign o_sync = stage_q[1];
endmodule

//--- hw/sfl_ctrl.sv
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
// How it works
// RL1 - Tx halts at frame end when FIFO empty.
// RL2 - DMA tx halt raises tx empty event.
// RL3 - Early tx FIFO drain aborts transmission.
// RL4 - Tx DMA request once beyond data count.
// RL5 - Write racing the halt leaves it stopped.
// RL6 - Empty status bit reads 0 with data.
// RL7 - Rx halts after programmed frame count.
// RL8 - Rx count halt raises rx stop event.
// RL9 - Rx DMA request persists until FIFO empty.
// RL10 - Frame limit spans 1 to 65536 frames.
// RL11 - Rx FIFO full at frame start aborts; before the first frame it waits in idle instead.
// RL12 - CPU continuous mode uses stop on empty.
// RL13 - CPU continuous halt raises tx stop event.
// RL14 - CPU must refill before FIFO drains.
// RL15 - Rx request drops one cycle between accesses.
// RL16 - Runs only with DMA on, master chosen.
// RL17 - Gap of 1 to 16 serial clocks.
// RL18 - Stop bit ends after current frame.
// RL19 - Count received frames from start, compare.
// RL20 - Resume only on a new start write.
module sfl_ctrl (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Register port
   input sfl_pkg::sfl_req_t i_bus,
   output logic [31:0] o_rdata,
   // Serial clock from the link
   input wire logic i_serial_clock,
   // Transmit FIFO side
   input wire logic i_tx_fifo_empty,
   input wire logic i_tx_fifo_full,
   input wire logic i_tx_fifo_wr,
   output logic o_tx_pop,
   output logic o_tx_dma_request,
   // Receive FIFO side
   input wire logic i_rx_fifo_empty,
   input wire logic i_rx_fifo_full,
   input wire logic i_rx_fifo_rd,
   output logic o_rx_push,
   output logic o_rx_dma_request,
   // Frame and event reporting
   output logic o_frame_active,
   output sfl_pkg::sfl_evt_t o_evt
);
   import sfl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State.
   typedef struct packed {
      sfl_state_t state;
      logic running;
      logic stop_pend;
      sfl_cfg_t cfg;
      logic [15:0] rx_lim;
      logic [3:0] gap;
      logic [15:0] rx_cnt;
      logic [3:0] bit_cnt;
      logic [3:0] gap_cnt;
      logic sclk_q;
      logic tx_wr_q;
      logic rx_rd_q;
      logic tx_pop;
      logic rx_push;
      sfl_evt_t evt;
      sfl_evt_t sticky;
      logic [31:0] rdata;
   } sfl_st_t;

   sfl_st_t st_q;
   sfl_st_t st_d;
   logic sclk_sync;
   logic sclk_edge;
   logic dma_master;
   logic start_wr;
   logic stop_wr;
   logic frame_end;

   function automatic logic sfl_hit(input sfl_req_t b, input logic [7:0] a);
      sfl_hit = (b.addr == a);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Serial clock crossing.
   sfl_sync u_sclk_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_async(i_serial_clock),
      .o_sync(sclk_sync)
   );

   assign sclk_edge = sclk_sync & ~st_q.sclk_q;
   // RL16 master DMA select
   assign dma_master = st_q.cfg.dma & ~st_q.cfg.ms;
   assign start_wr = i_bus.wr & sfl_hit(i_bus, SFL_ADDR_CTRL)
                     & i_bus.wdata[SFL_CTRL_START_BIT];
   assign stop_wr = i_bus.wr & sfl_hit(i_bus, SFL_ADDR_CTRL)
                    & i_bus.wdata[SFL_CTRL_STOP_BIT];
   assign frame_end = (st_q.state == SFL_FRAME) & sclk_edge
                      & (st_q.bit_cnt == SFL_FRAME_LAST);

   ////////////////////////////////////////////////////////////////////////
   // Next state.
   always_comb begin
      st_d = st_q;
      st_d.sclk_q = sclk_sync;
      st_d.tx_wr_q = i_tx_fifo_wr;
      st_d.rx_rd_q = i_rx_fifo_rd;
      st_d.tx_pop = 1'b0;
      st_d.rx_push = 1'b0;
      st_d.evt = '0;
      st_d.rdata = '0;

      // Register writes.
      if (i_bus.wr && sfl_hit(i_bus, SFL_ADDR_CFG)) begin
         st_d.cfg = sfl_cfg_t'(i_bus.wdata[4:0]);
      end
      // RL10 full 16-bit limit
      if (i_bus.wr && sfl_hit(i_bus, SFL_ADDR_RXLIM)) begin
         st_d.rx_lim = i_bus.wdata[15:0];
      end
      // RL17 gap setting
      if (i_bus.wr && sfl_hit(i_bus, SFL_ADDR_GAP)) begin
         st_d.gap = i_bus.wdata[3:0];
      end

      // Register reads; data stands in the following cycle only.
      if (i_bus.rd) begin
         case (i_bus.addr)
            SFL_ADDR_CFG: begin
               st_d.rdata[4:0] = st_q.cfg;
            end
            SFL_ADDR_CTRL: begin
               st_d.rdata[SFL_STAT_RUN_BIT] = st_q.running;
               st_d.rdata[SFL_STAT_STOPP_BIT] = st_q.stop_pend;
               // RL6 live empty status
               st_d.rdata[SFL_STAT_EMPTY_BIT] = i_tx_fifo_empty;
            end
            SFL_ADDR_RXLIM: begin
               st_d.rdata[15:0] = st_q.rx_lim;
            end
            SFL_ADDR_GAP: begin
               st_d.rdata[3:0] = st_q.gap;
            end
            SFL_ADDR_EVT: begin
               st_d.rdata[2:0] = st_q.sticky;
            end
            default: begin
               st_d.rdata = '0;
            end
         endcase
      end

      // RL20 restart on start
      if (start_wr && !st_q.running && dma_master) begin
         st_d.running = 1'b1;
         st_d.stop_pend = 1'b0;
         // RL19 count from start
         st_d.rx_cnt = '0;
         st_d.state = SFL_IDLE;
      end
      if (stop_wr && st_q.running) begin
         st_d.stop_pend = 1'b1;
      end

      case (st_q.state)
         SFL_IDLE: begin
            if (st_q.running && st_q.stop_pend) begin
               st_d.running = 1'b0;
               st_d.stop_pend = 1'b0;
            end else if (st_q.running
                         && (!st_q.cfg.tx_en || !i_tx_fifo_empty)
                         && (!st_q.cfg.rx_en || !i_rx_fifo_full)) begin
               st_d.state = SFL_FRAME;
               st_d.bit_cnt = '0;
               st_d.tx_pop = st_q.cfg.tx_en;
            end
         end
         SFL_FRAME: begin
            if (sclk_edge) begin
               st_d.bit_cnt = st_q.bit_cnt + 4'h1;
            end
            if (frame_end) begin
               // RL18 frame data kept
               st_d.rx_push = st_q.cfg.rx_en;
               st_d.rx_cnt = st_q.rx_cnt + 16'h0001;
               st_d.state = SFL_GAP;
               st_d.gap_cnt = '0;
               // RL7 frame limit halt
               if (st_q.cfg.rx_en && (st_q.rx_cnt == st_q.rx_lim)) begin
                  st_d.state = SFL_IDLE;
                  st_d.running = 1'b0;
                  // RL8 rx stop event
                  st_d.evt.rx_stop = 1'b1;
               end
               // RL1 halt when drained
               if (st_q.cfg.tx_en && i_tx_fifo_empty) begin
                  st_d.state = SFL_IDLE;
                  // RL5 racing write ignored
                  st_d.running = 1'b0;
                  // RL12 continuous mode halt
                  if (st_q.cfg.cont) begin
                     // RL13 tx stop event
                     st_d.evt.tx_stop = 1'b1;
                  end else begin
                     // RL2 tx empty event
                     st_d.evt.tx_empty = 1'b1;
                  end
               end
               // RL18 stop after frame
               if (st_q.stop_pend || stop_wr) begin
                  st_d.state = SFL_IDLE;
                  st_d.running = 1'b0;
                  st_d.stop_pend = 1'b0;
               end
            end
         end
         SFL_GAP: begin
            if (sclk_edge) begin
               st_d.gap_cnt = st_q.gap_cnt + 4'h1;
               // RL17 gap end
               if (st_q.gap_cnt == st_q.gap) begin
                  if (st_q.cfg.rx_en && i_rx_fifo_full) begin
                     // RL11 abort on full
                     st_d.state = SFL_IDLE;
                     st_d.running = 1'b0;
                  end else if (st_q.cfg.tx_en && i_tx_fifo_empty) begin
                     // RL3 abort on drain
                     st_d.state = SFL_IDLE;
                     st_d.running = 1'b0;
                  end else if (st_q.stop_pend) begin
                     st_d.state = SFL_IDLE;
                     st_d.running = 1'b0;
                     st_d.stop_pend = 1'b0;
                  end else begin
                     st_d.state = SFL_FRAME;
                     st_d.bit_cnt = '0;
                     st_d.tx_pop = st_q.cfg.tx_en;
                  end
               end
            end
         end
         default: begin
            st_d.state = SFL_IDLE;
            st_d.running = 1'b0;
         end
      endcase

      // An event in the clearing cycle wins over the clear.
      st_d.sticky = st_q.sticky & ~(i_bus.wr && sfl_hit(i_bus, SFL_ADDR_EVT)
                    ? sfl_evt_t'(i_bus.wdata[2:0]) : sfl_evt_t'(3'h0));
      st_d.sticky = st_d.sticky | st_d.evt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         st_q <= '{state: SFL_IDLE, cfg: '0, rx_lim: SFL_RXLIM_RST,
                   gap: SFL_GAP_RST, evt: '0, sticky: '0, rdata: '0,
                   default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign o_rdata = st_q.rdata;
   assign o_tx_pop = st_q.tx_pop;
   assign o_rx_push = st_q.rx_push;
   assign o_frame_active = (st_q.state == SFL_FRAME);
   assign o_evt = st_q.evt;
   // RL4 request while not full
   assign o_tx_dma_request = st_q.running & dma_master & st_q.cfg.tx_en
                             & ~st_q.cfg.cont & ~i_tx_fifo_full
                             & ~st_q.tx_wr_q;
   // RL9 drain regardless of run
   // RL15 low after access
   assign o_rx_dma_request = dma_master & ~i_rx_fifo_empty & ~st_q.rx_rd_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_frame_end;
      (st_q.state == SFL_FRAME) && sclk_edge
         && (st_q.bit_cnt == SFL_FRAME_LAST);
   endsequence

   sequence s_halted;
      !st_q.running && (st_q.state == SFL_IDLE);
   endsequence

   property p_tx_halt;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_frame_end and (st_q.cfg.tx_en && i_tx_fifo_empty) |=> s_halted;
   endproperty
   a_tx_halt: assert property (p_tx_halt) // RL1
      else $error("tx did not halt on drained fifo");

   property p_tx_empty_evt;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_frame_end and (st_q.cfg.tx_en && !st_q.cfg.cont && i_tx_fifo_empty)
      |=> o_evt.tx_empty ##1 st_q.sticky.tx_empty;
   endproperty
   a_tx_empty_evt: assert property (p_tx_empty_evt) // RL2
      else $error("tx empty event missing");

   property p_tx_stop_evt;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_frame_end and (st_q.cfg.tx_en && st_q.cfg.cont && i_tx_fifo_empty)
      |=> o_evt.tx_stop && !o_evt.tx_empty;
   endproperty
   a_tx_stop_evt: assert property (p_tx_stop_evt) // RL13
      else $error("tx stop event missing");

   property p_stay_stopped;
      @(posedge i_ref_clk) disable iff (i_rst)
      !st_q.running && !start_wr |=> !st_q.running;
   endproperty
   a_stay_stopped: assert property (p_stay_stopped) // RL5
      else $error("restarted without start write");

   property p_empty_flag;
      @(posedge i_ref_clk) disable iff (i_rst)
      i_bus.rd && (i_bus.addr == SFL_ADDR_CTRL) && !i_tx_fifo_empty
      |=> !o_rdata[SFL_STAT_EMPTY_BIT];
   endproperty
   a_empty_flag: assert property (p_empty_flag) // RL6
      else $error("empty flag set while data present");

   property p_rx_limit;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_frame_end and (st_q.cfg.rx_en && st_q.rx_cnt == st_q.rx_lim)
      |=> s_halted and o_evt.rx_stop and o_rx_push;
   endproperty
   a_rx_limit: assert property (p_rx_limit) // RL7
      else $error("rx did not halt at frame limit");

   property p_rx_req_gap;
      @(posedge i_ref_clk) disable iff (i_rst)
      o_rx_dma_request && i_rx_fifo_rd |=> !o_rx_dma_request;
   endproperty
   a_rx_req_gap: assert property (p_rx_req_gap) // RL15
      else $error("rx request not dropped after access");

   property p_rx_drain;
      @(posedge i_ref_clk) disable iff (i_rst)
      dma_master && !st_q.running && !i_rx_fifo_empty && !$past(i_rx_fifo_rd)
      |-> o_rx_dma_request;
   endproperty
   a_rx_drain: assert property (p_rx_drain) // RL9
      else $error("rx request missing while fifo holds data");

   property p_gap_end;
      @(posedge i_ref_clk) disable iff (i_rst)
      (st_q.state == SFL_GAP) && sclk_edge && (st_q.gap_cnt == st_q.gap)
      |=> st_q.state != SFL_GAP;
   endproperty
   a_gap_end: assert property (p_gap_end) // RL17
      else $error("gap overran its setting");

   property p_stop_frame;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_frame_end and st_q.stop_pend |=> s_halted;
   endproperty
   a_stop_frame: assert property (p_stop_frame) // RL18
      else $error("stop did not end transfer at frame end");

   property p_restart;
      @(posedge i_ref_clk) disable iff (i_rst)
      $rose(st_q.running) |-> $past(start_wr);
   endproperty
   a_restart: assert property (p_restart) // RL20
      else $error("run began without start write");

   property p_master_only;
      @(posedge i_ref_clk) disable iff (i_rst)
      $rose(st_q.running) |-> $past(dma_master);
   endproperty
   a_master_only: assert property (p_master_only) // RL16
      else $error("run began outside dma master mode");

   property p_tx_req_run;
      @(posedge i_ref_clk) disable iff (i_rst)
      o_tx_dma_request |-> st_q.running && !i_tx_fifo_full;
   endproperty
   a_tx_req_run: assert property (p_tx_req_run) // RL4
      else $error("tx request while idle or full");

   property p_rx_abort;
      @(posedge i_ref_clk) disable iff (i_rst)
      (st_q.state == SFL_GAP) && sclk_edge && (st_q.gap_cnt == st_q.gap)
      && st_q.cfg.rx_en && i_rx_fifo_full |=> s_halted;
   endproperty
   a_rx_abort: assert property (p_rx_abort) // RL11
      else $error("rx did not abort on full fifo");
endmodule

//--- dv/sfl_partner.sv
`timescale 1ns/10ps
// Both FIFOs as occupancy counters, a DMA that supplies a set number of
// words and drains the receive side. It never takes two words back to
// back, so each request must drop and rise again.
module sfl_partner (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Controller side
   input wire logic i_tx_pop,
   input wire logic i_tx_dma_request,
   input wire logic i_rx_push,
   input wire logic i_rx_dma_request,
   output logic o_tx_empty,
   output logic o_tx_full,
   output logic o_tx_wr,
   output logic o_rx_empty,
   output logic o_rx_full,
   output logic o_rx_rd,
   // Bench control
   input wire logic i_cpu_wr,
   input wire logic i_budget_wr,
   input wire logic [7:0] i_budget,
   output logic [4:0] o_rx_cnt
);
   logic [4:0] tx_cnt;
   logic [7:0] budget;
   logic dma_wr;
   logic go_tx;
   logic go_rx;
   assign o_tx_empty = (tx_cnt == 5'h00);
   assign o_tx_full = (tx_cnt == 5'h10);
   assign o_rx_empty = (o_rx_cnt == 5'h00);
   assign o_rx_full = (o_rx_cnt == 5'h10);
   assign o_tx_wr = dma_wr | i_cpu_wr;
   assign go_tx = i_tx_dma_request && (budget != 8'h00) && !dma_wr;
   assign go_rx = i_rx_dma_request && !o_rx_empty && !o_rx_rd;
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         tx_cnt <= 5'h00;
         o_rx_cnt <= 5'h00;
         budget <= 8'h00;
         dma_wr <= 1'b0;
         o_rx_rd <= 1'b0;
      end else begin
         dma_wr <= go_tx;
         o_rx_rd <= go_rx;
         budget <= i_budget_wr ? i_budget : budget - 8'(go_tx);
         tx_cnt <= tx_cnt + 5'(o_tx_wr) - 5'(i_tx_pop);
         o_rx_cnt <= o_rx_cnt + 5'(i_rx_push) - 5'(o_rx_rd);
      end
   end
endmodule

//--- dv/tb.sv
`timescale 1ns/10ps
module tb;
   import sfl_pkg::*;
   logic i_ref_clk, i_rst, i_serial_clock, cpu_wr, bud_wr;
   sfl_req_t i_bus;
   logic [31:0] o_rdata, d;
   logic tx_e, tx_f, tx_wr, tx_pop, tx_req, rx_e, rx_f, rx_rd, rx_push;
   logic rx_req, act;
   sfl_evt_t evt;
   logic [7:0] bud;
   logic [4:0] rx_cnt;
   int error_cnt, check_count, pops, pushes, rises, acts, n, lim;
   logic [7:0] addrs [5] = '{SFL_ADDR_CFG, SFL_ADDR_RXLIM, SFL_ADDR_GAP,
                            SFL_ADDR_EVT, 8'h20};
   sfl_ctrl uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus(i_bus),
      .o_rdata(o_rdata), .i_serial_clock(i_serial_clock),
      .i_tx_fifo_empty(tx_e), .i_tx_fifo_full(tx_f), .i_tx_fifo_wr(tx_wr),
      .o_tx_pop(tx_pop), .o_tx_dma_request(tx_req),
      .i_rx_fifo_empty(rx_e), .i_rx_fifo_full(rx_f), .i_rx_fifo_rd(rx_rd),
      .o_rx_push(rx_push), .o_rx_dma_request(rx_req),
      .o_frame_active(act), .o_evt(evt));
   sfl_partner far (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .i_tx_pop(tx_pop), .i_tx_dma_request(tx_req), .i_rx_push(rx_push),
      .i_rx_dma_request(rx_req), .o_tx_empty(tx_e), .o_tx_full(tx_f),
      .o_tx_wr(tx_wr), .o_rx_empty(rx_e), .o_rx_full(rx_f),
      .o_rx_rd(rx_rd), .i_cpu_wr(cpu_wr), .i_budget_wr(bud_wr),
      .i_budget(bud), .o_rx_cnt(rx_cnt));
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (error_cnt == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_ref_clk);
      i_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge i_ref_clk);
      i_bus <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge i_ref_clk);
      i_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge i_ref_clk);
      i_bus <= '0;
      #1 v = o_rdata;
   endtask
   task automatic pulse(input logic sel, input logic [7:0] v);
      @(posedge i_ref_clk);
      cpu_wr <= sel;
      bud_wr <= !sel;
      bud <= v;
      @(posedge i_ref_clk);
      cpu_wr <= 1'b0;
      bud_wr <= 1'b0;
   endtask
   // Bit 3 of the stop vector is a pop, bits 0..2 are the events.
   task automatic run(input int bitn, input int lim_c);
      logic rp, dp;
      logic [3:0] w;
      rp = 1'b0;
      dp = 1'b0;
      pops = 0;
      pushes = 0;
      rises = 0;
      acts = 0;
      for (int c = 0; c < lim_c; c++) begin
         @(posedge i_ref_clk);
         #1;
         pops += int'(tx_pop);
         pushes += int'(rx_push);
         acts += int'(act);
         if (tx_req && !rp) rises++;
         rp = tx_req;
         if (dp && rx_req) chk("rx_req_gap", 32'h0, 32'h1);
         dp = rx_rd;
         w = {tx_pop, evt};
         if (bitn >= 0 && w[bitn] === 1'b1) return;
      end
      if (bitn >= 0) begin
         chk("run_timeout", 32'h1, 32'h0);
         end_sim();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end
   // The link clock runs free so that gaps between frames can be timed.
   initial begin
      i_serial_clock = 1'b0;
      #137;
      forever #400 i_serial_clock = ~i_serial_clock;
   end
   initial begin
      error_cnt = 0;
      check_count = 0;
      i_rst = 1'b1;
      i_bus = '0;
      cpu_wr = 1'b0;
      bud_wr = 1'b0;
      bud = 8'h00;
      void'($urandom(96286));
      repeat (16) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      wr(8'h20, 32'hFFFF_FFFF);
      foreach (addrs[i]) begin
         rd(addrs[i], d);
         chk("reset_read", 32'h0, d);
      end
      wr(SFL_ADDR_RXLIM, 32'h0000_FFFF);
      rd(SFL_ADDR_RXLIM, d);
      chk("rxlim_max", 32'h0000_FFFF, d);
      n = $urandom_range(4, 1);
      wr(SFL_ADDR_GAP, 32'($urandom_range(15, 0)));
      wr(SFL_ADDR_CFG, 32'h05);
      pulse(1'b0, 8'(n));
      wr(SFL_ADDR_CTRL, 32'h1);
      run(SFL_EVT_TXEMP_BIT, 3000);
      chk("tx_pops", 32'(n), 32'(pops));
      chk("tx_req_rises", 32'(n + 1), 32'(rises));
      rd(SFL_ADDR_EVT, d);
      chk("evt_txemp", 32'h1, d);
      wr(SFL_ADDR_EVT, 32'h7);
      rd(SFL_ADDR_CTRL, d);
      chk("ctrl_empty", 32'h4, d);
      pulse(1'b1, 8'h00);
      run(-1, 200);
      chk("no_restart", 32'h0, 32'(pops));
      rd(SFL_ADDR_CTRL, d);
      chk("ctrl_data", 32'h0, d);
      wr(SFL_ADDR_CFG, 32'h07);
      wr(SFL_ADDR_CTRL, 32'h1);
      run(-1, 200);
      chk("slave_pops", 32'h0, 32'(pops));
      n = $urandom_range(3, 1);
      repeat (n) pulse(1'b1, 8'h00);
      wr(SFL_ADDR_CFG, 32'h15);
      wr(SFL_ADDR_CTRL, 32'h1);
      run(SFL_EVT_TXSTOP_BIT, 4000);
      chk("cont_pops", 32'(n + 1), 32'(pops));
      chk("cont_req", 32'h0, 32'(rises));
      rd(SFL_ADDR_EVT, d);
      chk("evt_txstop", 32'h2, d);
      wr(SFL_ADDR_EVT, 32'h7);
      lim = $urandom_range(6, 1);
      wr(SFL_ADDR_RXLIM, 32'(lim - 1));
      wr(SFL_ADDR_CFG, 32'h09);
      wr(SFL_ADDR_CTRL, 32'h1);
      run(SFL_EVT_RXSTOP_BIT, 5000);
      chk("rx_pushes", 32'(lim), 32'(pushes));
      rd(SFL_ADDR_EVT, d);
      chk("evt_rxstop", 32'h4, d);
      run(-1, 100);
      chk("rx_drained", 32'h0, 32'(rx_cnt));
      wr(SFL_ADDR_CFG, 32'h05);
      pulse(1'b0, 8'h06);
      wr(SFL_ADDR_CTRL, 32'h1);
      run(3, 500);
      wr(SFL_ADDR_CTRL, 32'h2);
      run(-1, 400);
      chk("stop_pops", 32'h0, 32'(pops));
      // A frame spans eight link clocks of eight core cycles each.
      chk("frame_kept", 32'h1, 32'(acts >= 48 && acts <= 72));
      rd(SFL_ADDR_CTRL, d);
      chk("ctrl_stopped", 32'h0, d);
      end_sim();
   end
endmodule
